// [hw/pscl_div.sv]
// edge-counting divider with equal high and low phases
`timescale 1ns/1ps
`default_nettype none
module pscl_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // synchronised input level and half period in input edges
  input wire logic in_lvl,
  input wire logic [8:0] half_count,
  // divided level
  output logic out_q
);
  logic prev_q; // last input level
  logic prev_d;
  logic [8:0] cnt_q; // rising edges in this half period
  logic [8:0] cnt_d;
  logic out_d;

  // toggle after half_count rising edges: same count high and low
  always_comb begin
    prev_d = in_lvl;
    cnt_d = cnt_q;
    out_d = out_q;
    if (in_lvl && !prev_q) begin
      if (cnt_q + 9'h001 >= half_count) begin
        cnt_d = 9'h000;
        out_d = !out_q;
      end else begin
        cnt_d = cnt_q + 9'h001;
      end
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      cnt_q <= 9'h000;
      out_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end
endmodule : pscl_div
`default_nettype wire

// [hw/pscl_loader.sv]
// configuration loader of the clock synthesizer, with apb register access
// Functional notes
// - reference divided by sixteen before comparison
// - output divisor one, two, four or eight
// - divided output has fifty percent duty
// - load strobe rising edge captures pins
// - parallel path overrides serial path
// - undriven divisor pins read as one
// - serial shift register is fourteen bits
// - shift one bit per shift clock rise
// - commit falling edge copies shift register
// - test output chosen by serial test bits
// - test mode six uses shift clock freely
// - loop divisor is plain unsigned binary
// - stream order: test, output, loop, msb first
// - codes 11,00,01,10 give one,two,four,eight
// - low load strobe makes pin latches transparent
// - low load strobe forces test bits zero
`timescale 1ns/1ps
`default_nettype none
module pscl_loader (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // parallel strap pins, with per-pin drive indication
  input wire logic par_load_n,
  input wire logic [8:0] par_m,
  input wire logic [8:0] par_m_driven,
  input wire logic [1:0] par_n,
  input wire logic [1:0] par_n_driven,
  // serial port pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_commit,
  // oscillator sources
  input wire logic crystal_osc_in,
  input wire logic external_reference_in,
  input wire logic controlled_oscillator,
  // outputs
  output logic ref_prescaled,
  output logic fout,
  output logic test_out,
  output pscl_pkg::pscl_cfg_t cfg_active
);
  // synchronised pins
  logic [28:0] pins_sync; // whole pin bundle after two flops
  pscl_pkg::pscl_ser_t ser_s;
  logic load_n_s; // synchronised load strobe
  logic [8:0] m_pin_s; // loop divisor pins after pull-up substitution
  logic [1:0] n_pin_s; // output divisor pins after pull-up substitution
  logic [8:0] m_raw_s, m_drv_s; // synchronised level and drive flag
  logic [1:0] n_raw_s, n_drv_s;
  logic [2:0] osc_s; // crystal, external ref, controlled osc
  logic ref_lvl; // selected reference level
  logic ref_div_q; // prescaled reference
  logic odiv_q; // divided oscillator level
  logic [8:0] odiv_half; // half period for the output divider

  // pins are asynchronous to pclk: two flops each before any logic
  // reads them, drive flags included, so no gate sits ahead of them
  pscl_sync #(.W(29)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({par_load_n, ser_clk, ser_data, ser_commit,
               crystal_osc_in, external_reference_in,
               controlled_oscillator, par_m, par_m_driven,
               par_n, par_n_driven}),
    .sync_out(pins_sync)
  );

  // split the synchronised bundle
  assign load_n_s = pins_sync[28];
  assign ser_s = pins_sync[27:25];
  assign osc_s = pins_sync[24:22];
  assign m_raw_s = pins_sync[21:13];
  assign m_drv_s = pins_sync[12:4];
  assign n_raw_s = pins_sync[3:2];
  assign n_drv_s = pins_sync[1:0];

  // an undriven pin reads one, as its pull-up would pull it
  // flags clear in reset, so the pins read all ones until synced
  assign m_pin_s = m_raw_s | ~m_drv_s;
  assign n_pin_s = n_raw_s | ~n_drv_s;

  // edge detect state
  logic sclk_prev_q, sclk_prev_d;
  logic commit_prev_q, commit_prev_d;
  logic load_prev_q, load_prev_d;
  logic sclk_rise, commit_fall, load_rise;

  assign sclk_rise = ser_s.clk && !sclk_prev_q;
  assign commit_fall = !ser_s.commit && commit_prev_q;
  assign load_rise = load_n_s && !load_prev_q;

  // control register: bit0 reference select, bit1 output enable
  logic [1:0] ctrl_q, ctrl_d;
  logic [pscl_pkg::SR_W-1:0] sr_q, sr_d; // serial shift register
  pscl_pkg::pscl_cfg_t cfg_q, cfg_d; // configuration latches
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic fout_q, fout_d;
  logic test_q, test_d;

  // crystal when select bit set, else the external reference
  assign ref_lvl = ctrl_q[0] ? osc_s[2] : osc_s[1];

  // reference prescaler ahead of the phase comparison
  pscl_div u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .in_lvl(ref_lvl),
    .half_count(pscl_pkg::PRESCALE_HALF),
    .out_q(ref_div_q)
  );

  // half period per output divisor code
  always_comb begin
    case (cfg_q.n)
      pscl_pkg::NSEL_DIV2: odiv_half = pscl_pkg::HALF_DIV2;
      pscl_pkg::NSEL_DIV4: odiv_half = pscl_pkg::HALF_DIV4;
      pscl_pkg::NSEL_DIV8: odiv_half = pscl_pkg::HALF_DIV8;
      default: odiv_half = pscl_pkg::HALF_DIV2;
    endcase
  end

  // output divider; toggling keeps high and low phases equal
  pscl_div u_outdiv (
    .pclk(pclk),
    .presetn(presetn),
    .in_lvl(osc_s[0]),
    .half_count(odiv_half),
    .out_q(odiv_q)
  );

  // edge detectors read the second sync stage only
  always_comb begin
    sclk_prev_d = ser_s.clk;
    commit_prev_d = ser_s.commit;
    load_prev_d = load_n_s;
  end

  // serial shift register
  always_comb begin
    sr_d = sr_q; // held after commits until new clocks arrive
    if (sclk_rise) begin
      // first bit in drifts to the top: t2 ends at bit 13
      sr_d = {sr_q[pscl_pkg::SR_W-2:0], ser_s.data};
    end
  end

  // configuration latches
  always_comb begin
    cfg_d = cfg_q;
    if (!load_n_s) begin
      // transparent to the pins while the strobe is low
      cfg_d.m = m_pin_s;
      cfg_d.n = n_pin_s;
      cfg_d.t = pscl_pkg::TSEL_QUIET;
    end else if (load_rise) begin
      // last pin values frozen on the release edge
      cfg_d.m = m_pin_s;
      cfg_d.n = n_pin_s;
    end else if (commit_fall) begin
      // only honoured with the strobe high
      cfg_d.t = sr_q[pscl_pkg::SR_T_LSB +: pscl_pkg::T_W];
      cfg_d.n = sr_q[pscl_pkg::SR_N_LSB +: pscl_pkg::N_W];
      cfg_d.m = sr_q[pscl_pkg::SR_M_LSB +: pscl_pkg::M_W];
    end
  end

  // output divisor select and output enable
  always_comb begin
    if (!ctrl_q[1]) begin
      fout_d = 1'b0; // disabled output holds fout low; test_out is not gated
    end else if (cfg_q.n == pscl_pkg::NSEL_DIV1) begin
      fout_d = osc_s[0];
    end else begin
      fout_d = odiv_q;
    end
  end

  // test output node select
  always_comb begin
    case (cfg_q.t)
      pscl_pkg::TSEL_QUIET: test_d = 1'b0;
      pscl_pkg::TSEL_REF: test_d = ref_lvl;
      pscl_pkg::TSEL_PRESCALE: test_d = ref_div_q;
      pscl_pkg::TSEL_OSC: test_d = osc_s[0];
      pscl_pkg::TSEL_FOUT: test_d = fout_q;
      pscl_pkg::TSEL_SR_MSB: test_d = sr_q[pscl_pkg::SR_W-1];
      pscl_pkg::TSEL_TESTCLK: test_d = ser_s.clk;
      pscl_pkg::TSEL_LOAD: test_d = load_n_s;
      default: test_d = 1'b0;
    endcase
  end

  // apb decode; zero wait states, unmapped answers with an error
  logic apb_setup;
  assign apb_setup = psel && !penable;

  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    err_d = 1'b0;
    if (apb_setup) begin
      // answer prepared in setup so access phase ends in one cycle
      case (paddr)
        pscl_pkg::ADDR_CTRL: begin
          rdata_d = {30'h00000000, ctrl_q};
        end
        pscl_pkg::ADDR_STATUS: begin
          rdata_d = {15'h0000, load_n_s, 2'h0, cfg_q};
        end
        pscl_pkg::ADDR_SHIFT: begin
          rdata_d = {18'h00000, sr_q};
        end
        default: begin
          rdata_d = 32'h00000000;
          err_d = 1'b1;
        end
      endcase
    end else if (psel && penable) begin
      // write takes effect on the completing edge
      err_d = err_q;
      if (pwrite && paddr == pscl_pkg::ADDR_CTRL) begin
        ctrl_d = pwdata[1:0];
      end
    end
  end

  assign pready = 1'b1; // always ready in the access phase
  assign prdata = rdata_q;
  assign pslverr = err_q && psel && penable;

  // edge history; clears to the synced idle level, so no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_q <= 1'b0;
      commit_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      commit_prev_q <= commit_prev_d;
      load_prev_q <= load_prev_d;
    end
  end

  // serial shift register, registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= pscl_pkg::RST_SR;
    end else begin
      sr_q <= sr_d;
    end
  end

  // configuration latches, registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= {pscl_pkg::RST_T, pscl_pkg::RST_N, pscl_pkg::RST_M};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // apb state, registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pscl_pkg::RST_CTRL;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // output levels, registered so the pins never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fout_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      fout_q <= fout_d;
      test_q <= test_d;
    end
  end

  // registered data outputs
  assign ref_prescaled = ref_div_q;
  assign fout = fout_q;
  assign test_out = test_q;
  assign cfg_active = cfg_q;
endmodule : pscl_loader
`default_nettype wire

// [hw/pscl_pkg.sv]
// shared constants and types of the synthesizer configuration loader
package pscl_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SHIFT = 8'h08;
  // field widths
  localparam int M_W = 9;
  localparam int N_W = 2;
  localparam int T_W = 3;
  localparam int SR_W = 14;
  // shift register field positions (first bit in ends at the top)
  localparam int SR_T_LSB = 11;
  localparam int SR_N_LSB = 9;
  localparam int SR_M_LSB = 0;
  // reference prescale: 16 = 2 x 8 edges per half period
  localparam logic [8:0] PRESCALE_HALF = 9'h008;
  // output divisor select codes
  localparam logic [1:0] NSEL_DIV1 = 2'h3;
  localparam logic [1:0] NSEL_DIV2 = 2'h0;
  localparam logic [1:0] NSEL_DIV4 = 2'h1;
  localparam logic [1:0] NSEL_DIV8 = 2'h2;
  // half-period edge counts for the divided outputs
  localparam logic [8:0] HALF_DIV2 = 9'h001;
  localparam logic [8:0] HALF_DIV4 = 9'h002;
  localparam logic [8:0] HALF_DIV8 = 9'h004;
  // test select codes
  localparam logic [2:0] TSEL_QUIET = 3'h0;
  localparam logic [2:0] TSEL_REF = 3'h1;
  localparam logic [2:0] TSEL_PRESCALE = 3'h2;
  localparam logic [2:0] TSEL_OSC = 3'h3;
  localparam logic [2:0] TSEL_FOUT = 3'h4;
  localparam logic [2:0] TSEL_SR_MSB = 3'h5;
  localparam logic [2:0] TSEL_TESTCLK = 3'h6;
  localparam logic [2:0] TSEL_LOAD = 3'h7;
  // reset values
  localparam logic [M_W-1:0] RST_M = 9'h1FF;
  localparam logic [N_W-1:0] RST_N = 2'h3;
  localparam logic [T_W-1:0] RST_T = 3'h0;
  localparam logic [SR_W-1:0] RST_SR = 14'h0000;
  localparam logic [1:0] RST_CTRL = 2'h3;
  // active divider configuration
  typedef struct packed {
    logic [T_W-1:0] t;
    logic [N_W-1:0] n;
    logic [M_W-1:0] m;
  } pscl_cfg_t;
  // serial port pins after synchronisation
  typedef struct packed {
    logic clk;
    logic data;
    logic commit;
  } pscl_ser_t;
endpackage : pscl_pkg

// [hw/pscl_sync.sv]
// bank of two-flop synchronisers for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pscl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // first stage, read only by second stage
  logic [W-1:0] stab_q; // second stage

  // one synchroniser per bit
  genvar gi;
  for (gi = 0; gi < W; gi++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[gi] <= 1'b0;
        stab_q[gi] <= 1'b0;
      end else begin
        meta_q[gi] <= async_in[gi];
        stab_q[gi] <= meta_q[gi];
      end
    end
  end

  assign sync_out = stab_q;
endmodule : pscl_sync
`default_nettype wire

// [verif/pscl_host.sv]
// host model driving the serial port of the loader
`timescale 1ns/1ps
`default_nettype none
module pscl_host (
  // clock
  input wire logic pclk,
  // serial port
  output var logic ser_clk,
  output var logic ser_data,
  output var logic ser_commit
);
  // idle: link clock stands low between frames
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_commit = 1'b0;
  end
  // one frame, msb first, 800 ns per bit, then a commit pulse
  task automatic send(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      ser_data <= w[i];
      ser_clk <= 1'b0;
      repeat (4) @(posedge pclk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    // data released: show the inverse so a stale level cannot pass
    ser_clk <= 1'b0;
    ser_data <= ~w[0];
    ser_commit <= 1'b1;
    repeat (4) @(posedge pclk);
    ser_commit <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : send
endmodule : pscl_host
`default_nettype wire

// [verif/pscl_loader_sva.sv]
// port assertions of the configuration loader
`timescale 1ns/1ps
`default_nettype none
module pscl_loader_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // strap and serial pins
  input wire logic par_load_n,
  input wire logic [8:0] par_m,
  input wire logic [8:0] par_m_driven,
  input wire logic ser_commit,
  // outputs watched
  input wire logic ref_prescaled,
  input wire logic test_out,
  input wire pscl_pkg::pscl_cfg_t cfg_active
);
  // one domain, so clock and reset are set once
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (psel && penable && paddr == 8'h0C
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable
    && paddr inside {8'h00, 8'h04, 8'h08} |-> !pslverr)
    else $error("error on a mapped register");
  // lag of three or four cycles, so six stable cycles are ample
  a_pins_follow: assert property (($stable(par_m)
    && $stable(par_m_driven) && !par_load_n) [*6]
    |-> cfg_active.m == (par_m | ~par_m_driven))
    else $error("loop divisor does not follow pins");
  a_test_cleared: assert property (!par_load_n [*6]
    |-> cfg_active.t == 3'h0) else $error("test bits not cleared");
  a_cfg_frozen: assert property ((par_load_n && !ser_commit) [*8]
    |-> $stable(cfg_active)) else $error("config moved without a load");
  a_test_quiet: assert property (cfg_active.t == 3'h0 [*3]
    |-> !test_out) else $error("test output active in quiet mode");
  a_prescale_slow: assert property ($changed(ref_prescaled)
    |=> $stable(ref_prescaled) [*8]) else $error("prescaled ref too fast");
endmodule : pscl_loader_sva
`default_nettype wire

// [verif/pscl_loader_tb.sv]
// self-checking bench of the configuration loader
`timescale 1ns/1ps
`default_nettype none
module pscl_loader_tb;
  // clock, reset and apb
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  // strap pins and oscillator stand-ins
  logic par_load_n;
  logic [8:0] par_m, par_m_driven;
  logic [1:0] par_n, par_n_driven;
  logic crystal_osc_in, external_reference_in, controlled_oscillator;
  // serial port and outputs
  logic ser_clk, ser_data, ser_commit, ref_prescaled, fout, test_out;
  pscl_pkg::pscl_cfg_t cfg_active;
  // bookkeeping
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 40;
  logic [31:0] qe[$]; // expected read data, oldest first
  logic [3:0] osc_cnt = 4'h0;
  pscl_loader i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .par_load_n, .par_m,
    .par_m_driven, .par_n, .par_n_driven, .ser_clk, .ser_data,
    .ser_commit, .crystal_osc_in, .external_reference_in,
    .controlled_oscillator, .ref_prescaled, .fout, .test_out, .cfg_active);
  pscl_host i_host (.pclk, .ser_clk, .ser_data, .ser_commit);
  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // oscillators well below pclk/4 so sampling divides exactly
  always @(posedge pclk) begin
    osc_cnt <= osc_cnt + 4'h1;
    crystal_osc_in <= osc_cnt[2];
    controlled_oscillator <= osc_cnt[2];
    external_reference_in <= osc_cnt[3];
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    qe.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // compare each completed read with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && qe.size() > 0) begin
      check("prdata", prdata, qe.pop_front());
      check("pslverr", {31'h0, pslverr},
        {31'h0, !(paddr inside {8'h00, 8'h04, 8'h08})});
    end
  end
  initial begin
    logic [13:0] w, pins;
    logic fo, pr, tp;
    int r, h, p, tr;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    par_load_n = 1'b0;
    par_m = 9'($random(seed));
    par_m_driven = 9'($random(seed));
    par_n = 2'($random(seed));
    par_n_driven = 2'($random(seed));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h3);
    apb(1'b1, 8'h00, 32'h2);
    rd(8'h00, 32'h2);
    apb(1'b1, 8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    // serial frame while the strobe is low must not win
    i_host.send(14'($random(seed)));
    pins = {3'h0, par_n | ~par_n_driven, par_m | ~par_m_driven};
    rd(8'h04, {15'h0, 1'b0, 2'h0, pins});
    par_load_n <= 1'b1;
    repeat (8) @(posedge pclk);
    par_m <= ~par_m;
    par_n <= ~par_n;
    repeat (8) @(posedge pclk);
    rd(8'h04, {15'h0, 1'b1, 2'h0, pins});
    for (int k = 0; k < 4; k++) begin
      // test nodes 3 to 6: oscillator, output, shift msb, test clock
      w = {3'(k + 3), 2'(k), 9'(200 + $unsigned($random(seed)) % 201)};
      i_host.send(w);
      rd(8'h04, {15'h0, 1'b1, 2'h0, w});
      rd(8'h08, {18'h0, w});
      // settle time stands in for the lock wait
      repeat (130) @(posedge pclk);
      {r, h, p, tr} = '0;
      @(negedge pclk);
      fo = fout;
      pr = ref_prescaled;
      tp = test_out;
      // 1024 cycles hold whole periods of every ratio
      repeat (1024) begin
        @(negedge pclk);
        r += int'(fout && !fo);
        h += int'(fout);
        p += int'(ref_prescaled && !pr);
        tr += int'(test_out && !tp);
        fo = fout;
        pr = ref_prescaled;
        tp = test_out;
      end
      @(posedge pclk);
      check("test rises", 32'(tr),
        (k == 0) ? 32'd128 : (k == 1) ? 32'd32 : 32'd0);
      check("fout rises", 32'(r), 32'(128 >> ((k + 1) % 4)));
      check("fout high", 32'(h), 32'd512);
      check("prescale rises", 32'(p), 32'd8);
    end
    finish_test();
  end
endmodule : pscl_loader_tb
bind pscl_loader pscl_loader_sva i_sva (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .par_load_n, .par_m, .par_m_driven,
  .ser_commit, .ref_prescaled, .test_out, .cfg_active);
`default_nettype wire
